// ==== prox_regs_pkg.sv ====
// package of offsets, reset values, field positions and states of the proximity register block
// Summary of operation
// - pulse count is driven from its complement register
// - complement resets all ones, meaning one pulse
// - flag bit 5 reports far to near
// - flag bit 4 reports near to far
// - flag bit 3 set when complements mismatch
// - bit 1 shows interrupt, bit 0 fresh result
// - result low at 0x9A, high at 0x9B
// - saturation bit 6, other bits read zero
// - control bit 3 selects interrupt pin polarity
// - mode 00 pin released, 01 proximity triggers
// - only fresh measurements are checked against thresholds
package prox_regs_pkg;

  // ----------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_DUTY_COMPL = 8'h95;
  localparam logic [7:0] OFS_CURRENT_COMPL = 8'h96;
  localparam logic [7:0] OFS_PULSE_COMPL = 8'h97;
  localparam logic [7:0] OFS_FLAGS = 8'h99;
  localparam logic [7:0] OFS_RESULT_LOW = 8'h9A;
  localparam logic [7:0] OFS_RESULT_HIGH = 8'h9B;
  localparam logic [7:0] OFS_SATURATION = 8'h9C;
  localparam logic [7:0] OFS_IRQ_CTRL = 8'hA7;

  // ----------------------------------------------------------------
  // reset values and compared field masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_DUTY_COMPL = 8'h01;
  localparam logic [7:0] RST_CURRENT_COMPL = 8'h10;
  localparam logic [7:0] RST_PULSE_COMPL = 8'hFF;
  localparam logic [7:0] RST_IRQ_CTRL = 8'h40;
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [7:0] MASK_DUTY = 8'h0F;
  localparam logic [7:0] MASK_CURRENT = 8'h1F;
  localparam logic [7:0] MASK_PULSE = 8'hFF;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int FLAG_APPROACH = 5;
  localparam int FLAG_RECEDE = 4;
  localparam int FLAG_INVALID = 3;
  localparam int FLAG_OVERRUN = 2;
  localparam int FLAG_IRQ = 1;
  localparam int FLAG_NEW = 0;
  localparam int SAT_BIT = 6;
  localparam int IRQ_POL_BIT = 3;
  localparam int IRQ_MODE_HI = 2;
  localparam int IRQ_MODE_LO = 1;
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_PROX = 2'h1;

  // serial bus: default address is arbitrary, last bit index of a byte
  localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2A;
  localparam logic [2:0] LAST_BIT = 3'h7;

  // serial slave states, gray along the write path; ack to read flips two bits
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_ADDR = 3'h1,
    ST_ACK = 3'h3,
    ST_WRITE = 3'h2,
    ST_READ = 3'h6,
    ST_RACK = 3'h7
  } bus_state_type;

endpackage

// ==== pin_sync.sv ====
// three stage pin synchroniser with agreement filter
`timescale 1ns/1ns
module pin_sync #(
  parameter logic RESET_LEVEL = 1'b1
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic level
);
  logic s1_q, s2_q, s3_q, level_q;

  // shift chain; first stage feeds only the second
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      s1_q <= RESET_LEVEL;
      s2_q <= RESET_LEVEL;
      s3_q <= RESET_LEVEL;
      level_q <= RESET_LEVEL;
    end else if (clk_en) begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) begin
        level_q <= s3_q; // change taken once stages two and three agree
      end
    end
  end

  assign level = level_q;
endmodule // pin_sync

// ==== prox_status_regs.sv ====
// proximity status, result and interrupt registers behind a serial bus slave
`timescale 1ns/1ns
module prox_status_regs #(
  parameter logic [6:0] DEV_ADDR = prox_regs_pkg::DEV_ADDR_DEFAULT,
  parameter int RESULT_WIDTH = 16
) (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  input wire logic [7:0] duty_setting,
  input wire logic [7:0] current_setting,
  input wire logic [7:0] pulse_count_setting,
  input wire logic meas_done,
  input wire logic [RESULT_WIDTH-1:0] meas_result,
  input wire logic approach_in,
  input wire logic recede_in,
  input wire logic saturation_in,
  input wire logic [15:0] integration_time,
  input wire logic [15:0] repeat_interval,
  input wire logic [RESULT_WIDTH-1:0] threshold_high,
  input wire logic [RESULT_WIDTH-1:0] threshold_low,
  output logic [7:0] pulse_count_active
);

  // ----------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------
  generate
    if (RESULT_WIDTH != 16) begin : g_bad_width
      $error("result must be two bytes wide");
    end
  endgenerate

  // ----------------------------------------------------------------
  // pin synchronisers and bus edge detection
  // ----------------------------------------------------------------
  logic scl_s, sda_s, scl_prev_q, sda_prev_q;

  pin_sync #(.RESET_LEVEL(1'b1)) u_scl_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in(scl_in),
    .level(scl_s)
  );

  pin_sync #(.RESET_LEVEL(1'b1)) u_sda_sync (
    .clock(clock),
    .sys_rst(sys_rst),
    .clk_en(clk_en),
    .pin_in(sda_in),
    .level(sda_s)
  );

  // previous filtered levels
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_prev_q <= 1'b1;
      sda_prev_q <= 1'b1;
    end else if (clk_en) begin
      scl_prev_q <= scl_s;
      sda_prev_q <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_prev_q;
  wire scl_fall = ~scl_s & scl_prev_q;
  wire start_cond = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
  wire stop_cond = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

  // ----------------------------------------------------------------
  // serial slave state machine
  // ----------------------------------------------------------------
  prox_regs_pkg::bus_state_type state_q;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q, tx_q, ptr_q;
  logic byte_full_q, rw_q, first_q, acked_q, sda_oe_q, sda_out_q;
  logic [7:0] read_byte;

  wire addr_hit = shift_q[7:1] == DEV_ADDR;
  wire byte_end = scl_fall & byte_full_q;
  wire in_addr = state_q == prox_regs_pkg::ST_ADDR;
  wire in_write = state_q == prox_regs_pkg::ST_WRITE;
  wire wr_byte_evt = byte_end & in_write;
  wire snap_evt = byte_end & in_addr & addr_hit & shift_q[0];
  wire load_evt = scl_fall & (((state_q == prox_regs_pkg::ST_ACK) & rw_q)
                  | ((state_q == prox_regs_pkg::ST_RACK) & acked_q));

  // bit level protocol; start and stop override any state
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_q <= prox_regs_pkg::ST_IDLE;
      bit_cnt_q <= '0;
      shift_q <= prox_regs_pkg::RST_BYTE;
      tx_q <= prox_regs_pkg::RST_BYTE;
      byte_full_q <= 1'b0;
      rw_q <= 1'b0;
      first_q <= 1'b0;
      acked_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (clk_en) begin
      if (start_cond) begin
        state_q <= prox_regs_pkg::ST_ADDR;
        bit_cnt_q <= '0;
        byte_full_q <= 1'b0;
        sda_oe_q <= 1'b0;
      end else if (stop_cond) begin
        state_q <= prox_regs_pkg::ST_IDLE;
        sda_oe_q <= 1'b0;
      end else begin
        unique case (state_q)
          prox_regs_pkg::ST_IDLE: begin
            sda_oe_q <= 1'b0;
          end
          prox_regs_pkg::ST_ADDR, prox_regs_pkg::ST_WRITE: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bit_cnt_q <= bit_cnt_q + 3'h1;
              byte_full_q <= bit_cnt_q == prox_regs_pkg::LAST_BIT;
            end else if (byte_end) begin
              byte_full_q <= 1'b0;
              if (in_write || addr_hit) begin
                state_q <= prox_regs_pkg::ST_ACK;
                sda_oe_q <= 1'b1; // acknowledge by pulling low
              end else begin
                state_q <= prox_regs_pkg::ST_IDLE;
              end
              if (in_addr) begin
                rw_q <= shift_q[0];
                first_q <= 1'b1;
              end else begin
                first_q <= 1'b0;
              end
            end
          end
          prox_regs_pkg::ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_q <= '0;
              if (rw_q) begin
                state_q <= prox_regs_pkg::ST_READ;
                tx_q <= read_byte;
                sda_oe_q <= ~read_byte[7];
              end else begin
                state_q <= prox_regs_pkg::ST_WRITE;
                sda_oe_q <= 1'b0;
              end
            end
          end
          prox_regs_pkg::ST_READ: begin
            if (scl_rise) begin
              bit_cnt_q <= bit_cnt_q + 3'h1;
              byte_full_q <= bit_cnt_q == prox_regs_pkg::LAST_BIT;
            end else if (byte_end) begin
              byte_full_q <= 1'b0;
              sda_oe_q <= 1'b0; // release for the master acknowledge
              state_q <= prox_regs_pkg::ST_RACK;
            end else if (scl_fall) begin
              tx_q <= {tx_q[6:0], 1'b0};
              sda_oe_q <= ~tx_q[6];
            end
          end
          prox_regs_pkg::ST_RACK: begin
            if (scl_rise) begin
              acked_q <= ~sda_s;
            end else if (scl_fall) begin
              bit_cnt_q <= '0;
              if (acked_q) begin
                state_q <= prox_regs_pkg::ST_READ;
                tx_q <= read_byte;
                sda_oe_q <= ~read_byte[7];
              end else begin
                state_q <= prox_regs_pkg::ST_IDLE;
              end
            end
          end
          default: begin
            state_q <= prox_regs_pkg::ST_IDLE;
            sda_oe_q <= 1'b0;
          end
        endcase
      end
    end
  end

  // register pointer: first written byte, then auto increment
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      ptr_q <= prox_regs_pkg::RST_BYTE;
    end else if (clk_en) begin
      if (wr_byte_evt && first_q) begin
        ptr_q <= shift_q;
      end else if (wr_byte_evt || load_evt) begin
        ptr_q <= ptr_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  logic [7:0] duty_compl_q, current_compl_q, pulse_compl_q, irq_ctrl_q;
  wire reg_wr = wr_byte_evt & ~first_q;

  // unmapped and read only offsets ignore writes
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      duty_compl_q <= prox_regs_pkg::RST_DUTY_COMPL;
      current_compl_q <= prox_regs_pkg::RST_CURRENT_COMPL;
      pulse_compl_q <= prox_regs_pkg::RST_PULSE_COMPL;
      irq_ctrl_q <= prox_regs_pkg::RST_IRQ_CTRL;
    end else if (clk_en && reg_wr) begin
      if (ptr_q == prox_regs_pkg::OFS_DUTY_COMPL) begin
        duty_compl_q <= shift_q;
      end
      if (ptr_q == prox_regs_pkg::OFS_CURRENT_COMPL) begin
        current_compl_q <= shift_q; // partner kept by host
      end
      if (ptr_q == prox_regs_pkg::OFS_PULSE_COMPL) begin
        pulse_compl_q <= shift_q;
      end
      if (ptr_q == prox_regs_pkg::OFS_IRQ_CTRL) begin
        irq_ctrl_q <= shift_q; // reserved bits stored as written
      end
    end
  end

  wire irq_pol = irq_ctrl_q[prox_regs_pkg::IRQ_POL_BIT];
  wire [1:0] irq_mode = irq_ctrl_q[prox_regs_pkg::IRQ_MODE_HI:prox_regs_pkg::IRQ_MODE_LO];

  // ----------------------------------------------------------------
  // measurement capture and live flags
  // ----------------------------------------------------------------
  logic [15:0] result_q;
  logic approach_q, recede_q, sat_q, irq_act_q, new_q;

  wire out_window = (meas_result > threshold_high) | (meas_result < threshold_low);
  wire irq_set = meas_done & (irq_mode == prox_regs_pkg::MODE_PROX) & out_window;
  wire rd_flags = load_evt & (ptr_q == prox_regs_pkg::OFS_FLAGS);
  wire rd_high = load_evt & (ptr_q == prox_regs_pkg::OFS_RESULT_HIGH);

  // complement checks over the used field bits
  wire duty_bad = ((duty_compl_q ^ ~duty_setting) & prox_regs_pkg::MASK_DUTY) != 8'h00;
  wire current_bad = ((current_compl_q ^ ~current_setting) & prox_regs_pkg::MASK_CURRENT) != 8'h00;
  wire pulse_bad = ((pulse_compl_q ^ ~pulse_count_setting) & prox_regs_pkg::MASK_PULSE) != 8'h00;
  wire settings_invalid = duty_bad | current_bad | pulse_bad;
  wire overrun = integration_time > repeat_interval;

  // result and direction captured per completed measurement
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      result_q <= '0;
      approach_q <= 1'b0;
      recede_q <= 1'b0;
      sat_q <= 1'b0;
    end else if (clk_en && meas_done) begin
      result_q <= meas_result;
      approach_q <= approach_in;
      recede_q <= recede_in;
      sat_q <= saturation_in;
    end
  end

  // hardware set wins over read clear
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_act_q <= 1'b0;
      new_q <= 1'b0;
    end else if (clk_en) begin
      irq_act_q <= irq_set | (irq_act_q & ~rd_flags);
      new_q <= meas_done | (new_q & ~rd_high);
    end
  end

  logic [7:0] flags_live, sat_live;

  // status and saturation byte assembly, reserved bits zero
  always_comb begin
    flags_live = '0;
    flags_live[prox_regs_pkg::FLAG_APPROACH] = approach_q;
    flags_live[prox_regs_pkg::FLAG_RECEDE] = recede_q;
    flags_live[prox_regs_pkg::FLAG_INVALID] = settings_invalid;
    flags_live[prox_regs_pkg::FLAG_OVERRUN] = overrun;
    flags_live[prox_regs_pkg::FLAG_IRQ] = irq_act_q;
    flags_live[prox_regs_pkg::FLAG_NEW] = new_q;
    sat_live = '0;
    sat_live[prox_regs_pkg::SAT_BIT] = sat_q;
  end

  // ----------------------------------------------------------------
  // read snapshot and read data selection
  // ----------------------------------------------------------------
  logic [7:0] snap_flags_q, snap_sat_q;
  logic [15:0] snap_result_q;

  // frozen at the address of each read so a block read is coherent
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      snap_flags_q <= prox_regs_pkg::RST_BYTE;
      snap_sat_q <= prox_regs_pkg::RST_BYTE;
      snap_result_q <= '0;
    end else if (clk_en && snap_evt) begin
      snap_flags_q <= flags_live;
      snap_sat_q <= sat_live;
      snap_result_q <= result_q;
    end
  end

  wire sel_duty = ptr_q == prox_regs_pkg::OFS_DUTY_COMPL;
  wire sel_current = ptr_q == prox_regs_pkg::OFS_CURRENT_COMPL;
  wire sel_pulse = ptr_q == prox_regs_pkg::OFS_PULSE_COMPL;
  wire sel_flags = ptr_q == prox_regs_pkg::OFS_FLAGS;
  wire sel_low = ptr_q == prox_regs_pkg::OFS_RESULT_LOW;
  wire sel_high = ptr_q == prox_regs_pkg::OFS_RESULT_HIGH;
  wire sel_sat = ptr_q == prox_regs_pkg::OFS_SATURATION;
  wire sel_irq = ptr_q == prox_regs_pkg::OFS_IRQ_CTRL;

  // unmapped offsets read zero
  assign read_byte = sel_duty ? duty_compl_q :
                     sel_current ? current_compl_q :
                     sel_pulse ? pulse_compl_q :
                     sel_flags ? snap_flags_q :
                     sel_low ? snap_result_q[7:0] :
                     sel_high ? snap_result_q[15:8] :
                     sel_sat ? snap_sat_q :
                     sel_irq ? irq_ctrl_q : prox_regs_pkg::RST_BYTE;

  // ----------------------------------------------------------------
  // output registers
  // ----------------------------------------------------------------
  logic irq_pin_out_q, irq_pin_oe_q;
  logic [7:0] pulse_active_q;

  // pin level from polarity, released when mode is off
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      irq_pin_out_q <= 1'b1;
      irq_pin_oe_q <= 1'b0;
      pulse_active_q <= ~prox_regs_pkg::RST_PULSE_COMPL;
      sda_out_q <= 1'b0;
    end else if (clk_en) begin
      irq_pin_out_q <= irq_act_q ? irq_pol : ~irq_pol;
      irq_pin_oe_q <= irq_mode == prox_regs_pkg::MODE_PROX;
      pulse_active_q <= ~pulse_compl_q; // code n means n+1 pulses
      sda_out_q <= 1'b0; // open drain, only ever pulls low
    end
  end

  assign sda_out = sda_out_q;
  assign sda_oe = sda_oe_q;
  assign irq_pin_out = irq_pin_out_q;
  assign irq_pin_oe = irq_pin_oe_q;
  assign pulse_count_active = pulse_active_q;

endmodule // prox_status_regs

// ==== prox_status_regs_properties.sv ====
// concurrent checks on the ports of the proximity register block
`timescale 1ns/1ns
module prox_status_regs_properties (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_oe,
  input wire logic irq_pin_out,
  input wire logic irq_pin_oe,
  input wire logic meas_done,
  input wire logic [7:0] pulse_count_active
);
  // ----------------------------------------------------------------
  // assertions, all on the one clock
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  a_reset_count: assert property ($fell(sys_rst) |-> pulse_count_active == 8'h00)
    else $error("pulse count not one pulse after reset");
  a_reset_pins: assert property ($fell(sys_rst) |-> !irq_pin_oe && irq_pin_out)
    else $error("interrupt pin not released after reset");
  a_reset_bus: assert property ($fell(sys_rst) |-> !sda_oe)
    else $error("data line driven after reset");
  a_count_by_write: assert property ($changed(pulse_count_active) |-> sda_oe)
    else $error("pulse count moved without a register write");
  a_pin_by_write: assert property ($changed(irq_pin_oe) |-> sda_oe)
    else $error("pin enable moved without a register write");
  a_pin_level_cause: assert property ($changed(irq_pin_out) && $past(irq_pin_oe) && irq_pin_oe
    |-> $past(meas_done, 2) || sda_oe)
    else $error("interrupt level moved without a fresh measurement");
  a_bus_change_low: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("data line changed while bus clock high");
  a_ack_holds: assert property ($rose(sda_oe) |=> sda_oe [*3])
    else $error("data line drive too short");

  // main scenarios reached
  c_measure: cover property (meas_done && irq_pin_oe);
  c_ack: cover property ($rose(sda_oe));
  c_pin_on: cover property ($rose(irq_pin_oe));
endmodule // prox_status_regs_properties

bind prox_status_regs prox_status_regs_properties prox_status_regs_properties_inst (
  .clock(clock),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_oe(sda_oe),
  .irq_pin_out(irq_pin_out),
  .irq_pin_oe(irq_pin_oe),
  .meas_done(meas_done),
  .pulse_count_active(pulse_count_active)
);

// ==== host_model.sv ====
// host side serial bus master model for the register port
`timescale 1ns/1ns
module host_model #(
  parameter logic [6:0] DEV_ADDR = prox_regs_pkg::DEV_ADDR_DEFAULT
) (
  input wire logic clock,
  input wire logic sda_oe,
  output logic scl_line,
  output logic sda_line
);
  logic sda_q = 1'h1;
  logic nack = 1'h0;
  logic [7:0] rd [0:3];

  // open-drain data wire with pull-up
  assign sda_line = sda_q & ~sda_oe;
  initial scl_line = 1'h1;

  // ----------------------------------------------------------------
  // bus phases, eight clocks per half period
  // ----------------------------------------------------------------
  task automatic half();
    repeat (8) @(posedge clock);
  endtask
  // data set in low phase, sampled at end of high phase
  task automatic bit_io(input logic v, output logic s);
    repeat (2) @(posedge clock);
    sda_q <= v;
    half();
    scl_line <= 1'h1;
    half();
    s = sda_line;
    scl_line <= 1'h0;
  endtask
  task automatic start_cond();
    half();
    sda_q <= 1'h1;
    half();
    scl_line <= 1'h1;
    half();
    sda_q <= 1'h0;
    half();
    scl_line <= 1'h0;
  endtask
  task automatic stop_cond();
    half();
    sda_q <= 1'h0;
    half();
    scl_line <= 1'h1;
    half();
    sda_q <= 1'h1;
    half();
  endtask
  task automatic send_byte(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'h1, s);
    nack = s;
  endtask
  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'h1, b[i]);
    bit_io(last, s);
  endtask

  // ----------------------------------------------------------------
  // register transfers
  // ----------------------------------------------------------------
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] val);
    start_cond();
    send_byte({DEV_ADDR, 1'h0});
    send_byte(ofs);
    send_byte(val);
    stop_cond();
  endtask
  // one contiguous read, pointer then repeated start
  task automatic read_regs(input logic [7:0] ofs, input int n);
    start_cond();
    send_byte({DEV_ADDR, 1'h0});
    send_byte(ofs);
    start_cond();
    send_byte({DEV_ADDR, 1'h1});
    for (int i = 0; i < n; i++) recv_byte(i == n - 1, rd[i]);
    stop_cond();
  endtask
  task automatic probe(input logic [6:0] addr);
    start_cond();
    send_byte({addr, 1'h0});
    stop_cond();
  endtask
endmodule // host_model

// ==== proximity_status_interrupt_regs_bench.sv ====
// self-checking bench for the proximity status and interrupt registers
`timescale 1ns/1ns
module proximity_status_interrupt_regs_bench;
  logic clock, sys_rst, clk_en, scl_line, sda_line, sda_out, sda_oe, irq_pin_out, irq_pin_oe;
  logic meas_done, approach_in, recede_in, saturation_in;
  logic [7:0] duty_setting, current_setting, pulse_count_setting, pulse_count_active;
  logic [15:0] meas_result, integration_time, repeat_interval, threshold_high, threshold_low;
  int miscompares = 0;
  int comparisons = 0;

  prox_status_regs prox_status_regs_inst (
    .clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe(sda_oe), .irq_pin_out(irq_pin_out), .irq_pin_oe(irq_pin_oe),
    .duty_setting(duty_setting), .current_setting(current_setting),
    .pulse_count_setting(pulse_count_setting), .meas_done(meas_done), .meas_result(meas_result),
    .approach_in(approach_in), .recede_in(recede_in), .saturation_in(saturation_in),
    .integration_time(integration_time), .repeat_interval(repeat_interval),
    .threshold_high(threshold_high), .threshold_low(threshold_low),
    .pulse_count_active(pulse_count_active));
  host_model host_model_inst (.clock(clock), .sda_oe(sda_oe), .scl_line(scl_line), .sda_line(sda_line));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rd1(input logic [7:0] ofs, input logic [7:0] exp);
    host_model_inst.read_regs(ofs, 1);
    check8(host_model_inst.rd[0], exp);
  endtask
  task automatic rd4(input logic [31:0] exp);
    host_model_inst.read_regs(prox_regs_pkg::OFS_FLAGS, 4);
    for (int i = 0; i < 4; i++) check8(host_model_inst.rd[i], exp[31-8*i -: 8]);
  endtask
  task automatic measure(input logic [15:0] res, input logic app, input logic rec, input logic sat);
    @(posedge clock);
    meas_result <= res;
    approach_in <= app;
    recede_in <= rec;
    saturation_in <= sat;
    meas_done <= 1'h1;
    @(posedge clock);
    meas_done <= 1'h0;
    repeat (3) @(posedge clock);
  endtask
  task automatic do_reset();
    @(posedge clock);
    sys_rst <= 1'h1;
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clock);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic test_reset_values();
    rd1(prox_regs_pkg::OFS_PULSE_COMPL, prox_regs_pkg::RST_PULSE_COMPL);
    check8(pulse_count_active, 8'h00);
    rd1(prox_regs_pkg::OFS_IRQ_CTRL, prox_regs_pkg::RST_IRQ_CTRL);
    check8({7'h00, irq_pin_oe}, 8'h00);
    check8({7'h00, sda_out}, 8'h00);
    rd4(32'h00000000);
  endtask
  task automatic test_pulse_count();
    @(posedge clock);
    pulse_count_setting <= 8'h0F;
    host_model_inst.write_reg(8'h97, 8'hF0);
    check8(pulse_count_active, 8'h0F);
    rd1(8'h99, 8'h00);
    host_model_inst.write_reg(8'h97, 8'hF1);
    rd1(8'h99, 8'h08);
    current_setting <= 8'h05;
    host_model_inst.write_reg(8'h96, 8'h1A);
    host_model_inst.write_reg(8'h97, 8'hF0);
    rd1(8'h99, 8'h00);
    pulse_count_setting <= 8'h00;
    current_setting <= 8'h0F;
    do_reset();
    check8(pulse_count_active, 8'h00);
    rd1(8'h97, 8'hFF);
  endtask
  task automatic test_irq_active_high();
    host_model_inst.write_reg(8'hA7, 8'h4A);
    check8({irq_pin_oe, irq_pin_out}, 8'h02);
    measure(16'h2345, 1'h1, 1'h0, 1'h1);
    check8({irq_pin_oe, irq_pin_out}, 8'h03);
    rd4(32'h23452340);
    rd1(8'h99, 8'h20);
    check8({7'h00, irq_pin_out}, 8'h00);
  endtask
  task automatic test_recede_overrun();
    integration_time <= 16'h001E;
    host_model_inst.write_reg(8'hA7, 8'h42);
    measure(16'h0050, 1'h0, 1'h1, 1'h0);
    check8({irq_pin_oe, irq_pin_out}, 8'h02);
    rd4(32'h17500000);
    integration_time <= 16'h000A;
    rd1(8'h99, 8'h10);
  endtask
  task automatic test_fresh_only();
    measure(16'h0800, 1'h0, 1'h0, 1'h0);
    threshold_high <= 16'h0400;
    repeat (20) @(posedge clock);
    check8({irq_pin_oe, irq_pin_out}, 8'h03);
    rd1(8'h99, 8'h01);
    threshold_high <= 16'h1000;
  endtask
  task automatic test_pin_released();
    host_model_inst.write_reg(8'hA7, 8'h48);
    check8({7'h00, irq_pin_oe}, 8'h00);
    measure(16'h0050, 1'h0, 1'h0, 1'h0);
    check8({7'h00, irq_pin_oe}, 8'h00);
    rd1(8'hA7, 8'h48);
    host_model_inst.write_reg(8'hA7, 8'h4C);
    check8({7'h00, irq_pin_oe}, 8'h00);
  endtask
  task automatic test_refusals();
    host_model_inst.probe(prox_regs_pkg::DEV_ADDR_DEFAULT ^ 7'h01);
    check8({7'h00, host_model_inst.nack}, 8'h01);
    host_model_inst.write_reg(8'h9A, 8'h55);
    check8({7'h00, host_model_inst.nack}, 8'h00);
    rd1(8'h9A, 8'h50);
    rd1(8'hF0, 8'h00);
  endtask

  // free-running system clock
  initial begin
    clock = 1'h0;
    forever #25 clock = ~clock;
  end

  // watchdog well past the expected run
  initial begin
    repeat (80000) @(posedge clock);
    miscompares++;
    end_of_test();
  end

  // main sequence
  initial begin
    sys_rst = 1'h1;
    clk_en = 1'h1;
    duty_setting = 8'h0E;
    current_setting = 8'h0F;
    pulse_count_setting = 8'h00;
    meas_done = 1'h0;
    meas_result = 16'h0000;
    approach_in = 1'h0;
    recede_in = 1'h0;
    saturation_in = 1'h0;
    integration_time = 16'h000A;
    repeat_interval = 16'h0014;
    threshold_high = 16'h1000;
    threshold_low = 16'h0100;
    repeat (10) @(posedge clock);
    sys_rst <= 1'h0;
    repeat (4) @(posedge clock);
    test_reset_values();
    test_pulse_count();
    test_irq_active_high();
    test_recede_overrun();
    test_fresh_only();
    test_pin_released();
    test_refusals();
    end_of_test();
  end
endmodule // proximity_status_interrupt_regs_bench
